// ### rtl/spl_cfg.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 soft pin profile loader. Assumes inclusion by bare name from rtl/.
*/
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH
`define SPL_ADDR_SEC1_EN 12'hc00
`define SPL_ADDR_XLAT_SEL 12'hc01
`define SPL_ADDR_SPLL_SEL 12'hc02
`define SPL_ADDR_SEC2_EN 12'hc03
`define SPL_ADDR_IN_SCALE 12'hc04
`define SPL_ADDR_OUT_SCALE 12'hc05
`define SPL_ADDR_LOOP_SET 12'hc06
`define SPL_ADDR_START 12'hc07
`define SPL_ADDR_SP_RESET 12'hc08
`define SPL_ADDR_STATUS 12'hc09
`define SPL_RST_BYTE 8'h00
`define SPL_IN_A_LSB 0
`define SPL_IN_B_LSB 2
`define SPL_OUT_0_LSB 0
`define SPL_OUT_1_LSB 2
`define SPL_TOL_LSB 0
`define SPL_BW_LSB 2
`define SPL_OUT_SEL_LSB 4
`define SPL_ROM_WORDS 9
`define SPL_ROM_CYCLES 2
`endif

// ### rtl/spl_pkg.sv
/*
 Types of the soft pin profile loader.
 Assumes the constants header is compiled beside it.
*/
package spl_pkg;
  typedef enum logic [1:0] {SPL_IDLE, SPL_FETCH, SPL_DONE} spl_state_t;
  typedef logic [11:0] spl_addr_t;
  typedef logic [7:0] spl_byte_t;
endpackage

// ### rtl/spl_loader.sv
/*
 Soft pin profile loader: register file, strap capture and ROM download
 sequencer that produces divider, tuning and system PLL settings.
 Assumes a plain one-cycle strobe register port on i_clk and an external
 preset ROM answering o_rom_word at most SPL_ROM_CYCLES - 1 cycles later.
*/
// Notes on behaviour
// - Section one enable defaults off; needs strap low
// - Strap high ignores section one registers
// - Section one picks one of 256 translations
// - Upper nibble reloads output side dividers
// - Lower nibble reloads all reference profiles
// - Two-bit field reloads system PLL setup
// - Four fixed system PLL presets
// - Section two enable defaults off; strap low
// - Reference B input scaling 1/4/8/16
// - Reference A input scaling 1/4/8/16
// - Channel one output scaling 1/4/8/16
// - Channel zero output scaling 1/4/8/16
// - Loop bandwidth code 50/1/10/100 Hz
// - Frequency tolerance code selects window
// - Start bit downloads, self clears after
// - Soft pin reset downloads, self clears
`timescale 1ns/1ps
`include "spl_cfg.svh"
module spl_loader #(
  parameter int ROM_CYCLES = `SPL_ROM_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Strap pin
  input wire logic i_strap_select_pin,
  // Register port
  input wire spl_pkg::spl_addr_t i_addr,
  input wire spl_pkg::spl_byte_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output spl_pkg::spl_byte_t o_rdata,
  // Preset ROM port
  output logic [7:0] o_rom_addr,
  output logic [3:0] o_rom_word,
  input wire logic [31:0] i_rom_data,
  // Loaded settings
  output logic [31:0] o_free_run_tuning_word,
  output logic [15:0] o_output_pll_feedback_divider,
  output logic [7:0] o_vco_output_divider,
  output logic [63:0] o_channel_dividers,
  output logic [31:0] o_reference_period,
  output logic [19:0] o_reference_divider,
  output logic [16:0] o_dpll_integer_feedback,
  output logic [22:0] o_dpll_fractional_feedback,
  output logic [22:0] o_dpll_feedback_modulus,
  output logic [15:0] o_sys_pll_config,
  // Scaling and loop settings, section activity, soft reset and busy
  output logic [4:0] o_ref_a_div,
  output logic [4:0] o_ref_b_div,
  output logic [4:0] o_chan0_div,
  output logic [4:0] o_chan1_div,
  output logic [1:0] o_loop_bw_code,
  output logic [1:0] o_tolerance_code,
  output logic o_soft_sec1_active,
  output logic o_soft_sec2_active,
  output logic o_soft_reset,
  output logic o_busy
);
  import spl_pkg::*;

  // Refuse wait counts outside 1 to 15; the 4-bit wait counter reaches 15 at most
  if (ROM_CYCLES < 1 || ROM_CYCLES > 15) begin : g_bad_rom_cycles
    $error("ROM_CYCLES out of range");
  end

  logic [7:0] sec1_reg, xlat_reg, spll_reg, sec2_reg, insc_reg, outsc_reg, loop_reg;
  logic start_reg, sprst_reg, strap_m_reg, strap_s_reg, strap_reg;
  spl_state_t state_reg, state_next;
  logic [3:0] word_reg, wait_reg;

  // Register decode
  wire wr_sec1 = i_wr && i_addr == `SPL_ADDR_SEC1_EN;
  wire wr_xlat = i_wr && i_addr == `SPL_ADDR_XLAT_SEL;
  wire wr_spll = i_wr && i_addr == `SPL_ADDR_SPLL_SEL;
  wire wr_sec2 = i_wr && i_addr == `SPL_ADDR_SEC2_EN;
  wire wr_insc = i_wr && i_addr == `SPL_ADDR_IN_SCALE;
  wire wr_outsc = i_wr && i_addr == `SPL_ADDR_OUT_SCALE;
  wire wr_loop = i_wr && i_addr == `SPL_ADDR_LOOP_SET;
  wire wr_start = i_wr && i_addr == `SPL_ADDR_START && i_wdata[0];
  wire wr_sprst = i_wr && i_addr == `SPL_ADDR_SP_RESET && i_wdata[0];
  // Section activity gated by the captured strap level
  wire sec1_on = sec1_reg[0] && !strap_reg;
  wire sec2_on = sec2_reg[0] && !strap_reg;
  wire fetch_last = state_reg == SPL_FETCH && wait_reg == 4'(ROM_CYCLES) &&
                    word_reg == 4'(`SPL_ROM_WORDS - 1);
  wire rom_take = state_reg == SPL_FETCH && wait_reg == 4'(ROM_CYCLES);
  wire launch = state_reg == SPL_IDLE && (start_reg || sprst_reg) && sec1_on;

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    i_addr == `SPL_ADDR_SEC1_EN ? {7'h00, sec1_reg[0]} :
    i_addr == `SPL_ADDR_XLAT_SEL ? xlat_reg :
    i_addr == `SPL_ADDR_SPLL_SEL ? {6'h00, spll_reg[1:0]} :
    i_addr == `SPL_ADDR_SEC2_EN ? {7'h00, sec2_reg[0]} :
    i_addr == `SPL_ADDR_IN_SCALE ? {4'h0, insc_reg[3:0]} :
    i_addr == `SPL_ADDR_OUT_SCALE ? {4'h0, outsc_reg[3:0]} :
    i_addr == `SPL_ADDR_LOOP_SET ? {4'h0, loop_reg[3:0]} :
    i_addr == `SPL_ADDR_START ? {7'h00, start_reg} :
    i_addr == `SPL_ADDR_SP_RESET ? {7'h00, sprst_reg} :
    i_addr == `SPL_ADDR_STATUS ? {5'h00, strap_reg, o_soft_sec1_active, o_busy} : 8'h00;

  // Scale code to divide ratio: 1, 4, 8, 16
  function automatic logic [4:0] scale_div(input logic [1:0] code);
    unique case (code)
      2'b00: scale_div = 5'h01;
      2'b01: scale_div = 5'h04;
      2'b10: scale_div = 5'h08;
      2'b11: scale_div = 5'h10;
    endcase
  endfunction

  // Presets in code order: ref MHz is only a label; config packs x2, N
  function automatic logic [15:0] spll_preset(input logic [1:0] code);
    unique case (code)
      2'b00: spll_preset = 16'h1010; // 24.576 MHz crystal, x2 on, N 16
      2'b01: spll_preset = 16'h1008; // 49.152 MHz crystal, x2 on, N 8
      2'b10: spll_preset = 16'h0020; // 24.576 MHz oscillator, x2 off, N 32
      2'b11: spll_preset = 16'h0010; // 49.152 MHz oscillator, x2 off, N 16
    endcase
  endfunction

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPL_IDLE: if (launch) state_next = SPL_FETCH;
      SPL_FETCH: if (fetch_last) state_next = SPL_DONE;
      SPL_DONE: state_next = SPL_IDLE;
    endcase
  end

  // Strap capture window: three edges after reset release
  logic strap_hold;
  logic [1:0] hold_cnt_reg;
  assign strap_hold = hold_cnt_reg == 2'h3;

  // Strap synchroniser; both stages reset high so that hard pin mode
  // holds until a synchronised sample exists, with no false low in between
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_m_reg <= 1'b1;
      strap_s_reg <= 1'b1;
      strap_reg <= 1'b1;
    end else begin
      strap_m_reg <= i_strap_select_pin;
      strap_s_reg <= strap_m_reg;
      if (!strap_hold) strap_reg <= strap_s_reg;
    end
  end

  // Held after the capture window until next reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) hold_cnt_reg <= 2'h0;
    else if (!strap_hold) hold_cnt_reg <= hold_cnt_reg + 2'h1;
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sec1_reg <= `SPL_RST_BYTE;
      xlat_reg <= `SPL_RST_BYTE;
      spll_reg <= `SPL_RST_BYTE;
      sec2_reg <= `SPL_RST_BYTE;
      insc_reg <= `SPL_RST_BYTE;
      outsc_reg <= `SPL_RST_BYTE;
      loop_reg <= `SPL_RST_BYTE;
    end else begin
      if (wr_sec1) sec1_reg <= i_wdata;
      if (wr_xlat) xlat_reg <= i_wdata;
      if (wr_spll) spll_reg <= i_wdata;
      if (wr_sec2) sec2_reg <= i_wdata;
      if (wr_insc) insc_reg <= i_wdata;
      if (wr_outsc) outsc_reg <= i_wdata;
      if (wr_loop) loop_reg <= i_wdata;
    end
  end

  // Self-clearing trigger bits; a new write wins over the clear.
  // A trigger stays pending while section one is off, so it is never lost
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_reg <= 1'b0;
      sprst_reg <= 1'b0;
    end else begin
      start_reg <= wr_start || (start_reg && state_reg != SPL_DONE);
      sprst_reg <= wr_sprst || (sprst_reg && state_reg != SPL_DONE);
    end
  end

  // Sequencer, word walk and ROM wait count.
  // One word per ROM_CYCLES + 1 cycles; a slower ROM only needs a larger count
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= SPL_IDLE;
      word_reg <= 4'h0;
      wait_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg != SPL_FETCH) wait_reg <= 4'h0;
      else if (rom_take) wait_reg <= 4'h0;
      else wait_reg <= wait_reg + 4'h1;
      if (state_reg != SPL_FETCH) word_reg <= 4'h0;
      else if (rom_take) word_reg <= word_reg + 4'h1;
    end
  end

  // ROM address: output nibble, input nibble, word index
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rom_addr <= 8'h00;
      o_rom_word <= 4'h0;
      o_busy <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_rom_addr <= xlat_reg;
      o_rom_word <= word_reg;
      o_busy <= state_next != SPL_IDLE;
      o_soft_reset <= launch && sprst_reg;
    end
  end

  // Loaded settings; words 0-3 output side, 4-8 input side
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_free_run_tuning_word <= 32'h0;
      o_output_pll_feedback_divider <= 16'h0;
      o_vco_output_divider <= 8'h0;
      o_channel_dividers <= 64'h0;
      o_reference_period <= 32'h0;
      o_reference_divider <= 20'h0;
      o_dpll_integer_feedback <= 17'h0;
      o_dpll_fractional_feedback <= 23'h0;
      o_dpll_feedback_modulus <= 23'h0;
      o_sys_pll_config <= 16'h0;
    end else begin
      if (rom_take) begin
        unique case (word_reg)
          4'h0: o_free_run_tuning_word <= i_rom_data;
          4'h1: {o_vco_output_divider, o_output_pll_feedback_divider} <= i_rom_data[23:0];
          4'h2: o_channel_dividers[31:0] <= i_rom_data;
          4'h3: o_channel_dividers[63:32] <= i_rom_data;
          4'h4: o_reference_period <= i_rom_data;
          4'h5: o_reference_divider <= i_rom_data[19:0];
          4'h6: o_dpll_integer_feedback <= i_rom_data[16:0];
          4'h7: o_dpll_fractional_feedback <= i_rom_data[22:0];
          default: o_dpll_feedback_modulus <= i_rom_data[22:0];
        endcase
      end
      if (state_reg == SPL_DONE) o_sys_pll_config <= spll_preset(spll_reg[1:0]);
    end
  end

  // Scaling and loop outputs; neutral values when section two is off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ref_a_div <= 5'h01;
      o_ref_b_div <= 5'h01;
      o_chan0_div <= 5'h01;
      o_chan1_div <= 5'h01;
      o_loop_bw_code <= 2'h0;
      o_tolerance_code <= 2'h0;
      o_soft_sec1_active <= 1'b0;
      o_soft_sec2_active <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_ref_a_div <= sec2_on ? scale_div(insc_reg[`SPL_IN_A_LSB +: 2]) : 5'h01;
      o_ref_b_div <= sec2_on ? scale_div(insc_reg[`SPL_IN_B_LSB +: 2]) : 5'h01;
      o_chan0_div <= sec2_on ? scale_div(outsc_reg[`SPL_OUT_0_LSB +: 2]) : 5'h01;
      o_chan1_div <= sec2_on ? scale_div(outsc_reg[`SPL_OUT_1_LSB +: 2]) : 5'h01;
      o_loop_bw_code <= sec2_on ? loop_reg[`SPL_BW_LSB +: 2] : 2'h0;
      o_tolerance_code <= sec2_on ? loop_reg[`SPL_TOL_LSB +: 2] : 2'h0;
      o_soft_sec1_active <= sec1_on;
      o_soft_sec2_active <= sec2_on;
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

  // Checks
  a_strap_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    strap_reg |-> state_reg == SPL_IDLE || $past(sec1_on)) else $error("download ran with strap high");
  a_sec1_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (sec1_reg[0] && !strap_reg) |=> o_soft_sec1_active) else $error("section one not active");
  a_sec2_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !sec2_on |=> o_ref_a_div == 5'h01 && o_chan1_div == 5'h01) else $error("scaling leaked");
  a_start_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == SPL_DONE && !wr_start |=> !start_reg) else $error("start bit stuck");
  a_launch_busy: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    launch |=> o_busy ##0 state_reg == SPL_FETCH) else $error("download did not begin");
  a_download_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    launch |-> ##[1:200] state_reg == SPL_DONE) else $error("download too long");
  a_sprst_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (launch && sprst_reg) |=> o_soft_reset ##1 !o_soft_reset) else $error("soft reset pulse wrong");
  a_spll_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == SPL_DONE |=> o_sys_pll_config == spll_preset($past(spll_reg[1:0]))) else $error("pll preset");
  a_scale_b: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sec2_on && insc_reg[3:2] == 2'b11 |=> o_ref_b_div == 5'h10) else $error("ref b scale");
  c_download: cover property (@(posedge i_clk) disable iff (!i_rst_b) launch ##[1:100] state_reg == SPL_DONE);
  c_sprst: cover property (@(posedge i_clk) disable iff (!i_rst_b) launch && sprst_reg);
  c_sec2: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_soft_sec2_active && o_chan0_div == 5'h08);

  // Strap capture and trigger bit holding
  a_strap_held: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    strap_hold |=> $stable(strap_reg)) else $error("strap level moved after capture");
  a_start_pending: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    start_reg && state_reg == SPL_IDLE |=> start_reg) else $error("pending start lost");
  a_sprst_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == SPL_DONE && !wr_sprst |=> !sprst_reg) else $error("soft pin reset bit stuck");
  a_done_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg == SPL_DONE |=> !o_busy && state_reg == SPL_IDLE) else $error("busy after download");

  // Scaling and loop codes follow section two
  a_scale_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sec2_on && insc_reg[1:0] == 2'b01 |=> o_ref_a_div == 5'h04) else $error("ref a scale");
  a_scale_chan0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sec2_on && outsc_reg[1:0] == 2'b10 |=> o_chan0_div == 5'h08) else $error("channel 0 scale");
  a_scale_chan1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sec2_on && outsc_reg[3:2] == 2'b11 |=> o_chan1_div == 5'h10) else $error("channel 1 scale");
  a_loop_codes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sec2_on |=> o_loop_bw_code == $past(loop_reg[3:2]) && o_tolerance_code == $past(loop_reg[1:0]))
    else $error("loop codes");

  // ROM words land in their settings
  a_tuning_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rom_take && word_reg == 4'h0 |=> o_free_run_tuning_word == $past(i_rom_data)) else $error("tuning word");
  a_vco_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rom_take && word_reg == 4'h1 |=> o_vco_output_divider == $past(i_rom_data[23:16])) else $error("vco div");
  a_modulus_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rom_take && word_reg == 4'h8 |=> o_dpll_feedback_modulus == $past(i_rom_data[22:0])) else $error("modulus");
  a_rom_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_rom_addr == $past(xlat_reg)) else $error("rom address");

  // Scenario covers
  c_hard_pending: cover property (@(posedge i_clk) disable iff (!i_rst_b) start_reg && strap_reg && strap_hold);
  c_ref_a_scale: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_soft_sec2_active && o_ref_a_div == 5'h10);
endmodule // spl_loader

// ### dv/test_soft_pin_profile_loader.sv
/*
 Self-checking bench of the soft pin profile loader: register access, scaling
 codes, ROM downloads, soft pin reset and hard pin strap.
 Assumes spl_cfg.svh on the include path and spl_pkg compiled first.
*/
`timescale 1ns/1ps
`include "spl_cfg.svh"
module test_soft_pin_profile_loader;
  import spl_pkg::*;
  // Stimulus and observed signals
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_strap_select_pin = 1'b1;
  spl_addr_t i_addr = 12'h000;
  spl_byte_t i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] i_rom_data = 32'h0000_0000;
  spl_byte_t o_rdata;
  logic [7:0] o_rom_addr, o_vco_output_divider;
  logic [3:0] o_rom_word;
  logic [31:0] o_free_run_tuning_word, o_reference_period;
  logic [15:0] o_output_pll_feedback_divider, o_sys_pll_config;
  logic [63:0] o_channel_dividers;
  logic [19:0] o_reference_divider;
  logic [16:0] o_dpll_integer_feedback;
  logic [22:0] o_dpll_fractional_feedback, o_dpll_feedback_modulus;
  logic [4:0] o_ref_a_div, o_ref_b_div, o_chan0_div, o_chan1_div;
  logic [1:0] o_loop_bw_code, o_tolerance_code;
  logic o_soft_sec1_active, o_soft_sec2_active, o_soft_reset, o_busy;
  int failures = 0;
  int check_count = 0;
  int sr_count = 0;
  logic rd_pipe = 1'b0;
  spl_byte_t exp_q[$];
  logic [4:0] div_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  logic [15:0] spll_tab [4] = '{16'h1010, 16'h1008, 16'h0020, 16'h0010};

  spl_loader #(.ROM_CYCLES(2)) spl_loader_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_strap_select_pin(i_strap_select_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_rom_addr(o_rom_addr), .o_rom_word(o_rom_word), .i_rom_data(i_rom_data),
    .o_free_run_tuning_word(o_free_run_tuning_word), .o_output_pll_feedback_divider(o_output_pll_feedback_divider),
    .o_vco_output_divider(o_vco_output_divider), .o_channel_dividers(o_channel_dividers),
    .o_reference_period(o_reference_period), .o_reference_divider(o_reference_divider),
    .o_dpll_integer_feedback(o_dpll_integer_feedback), .o_dpll_fractional_feedback(o_dpll_fractional_feedback),
    .o_dpll_feedback_modulus(o_dpll_feedback_modulus), .o_sys_pll_config(o_sys_pll_config),
    .o_ref_a_div(o_ref_a_div), .o_ref_b_div(o_ref_b_div), .o_chan0_div(o_chan0_div), .o_chan1_div(o_chan1_div),
    .o_loop_bw_code(o_loop_bw_code), .o_tolerance_code(o_tolerance_code), .o_soft_sec1_active(o_soft_sec1_active),
    .o_soft_sec2_active(o_soft_sec2_active), .o_soft_reset(o_soft_reset), .o_busy(o_busy));

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  // Preset ROM contents: distinct per address and word so swaps show up
  function automatic logic [31:0] rom_f(input logic [7:0] a, input logic [3:0] w);
    return {a, ~a, 4'h0, w, 4'h9, w};
  endfunction
  always @(posedge i_clk) i_rom_data <= rom_f(o_rom_addr, o_rom_word);

  // Read data stand in the cycle after the strobe cycle, and only there
  always @(posedge i_clk) rd_pipe <= i_rd;
  always @(negedge i_clk) if (rd_pipe === 1'b1) chk(o_rdata, exp_q.pop_front());
  always @(posedge i_clk) if (o_soft_reset === 1'b1) sr_count++;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input spl_addr_t a, input spl_byte_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input spl_addr_t a, input spl_byte_t e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // Bounded wait, so a stuck sequencer ends as a mismatch and not a hang
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (o_busy !== lvl && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    if (o_busy !== lvl) begin
      failures++;
      $display("[ERR] %0t busy wait timed out", $time);
    end
  endtask
  task automatic do_reset(input logic strap);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_strap_select_pin <= strap;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    idle(8);
  endtask
  task automatic dl_check(input logic [7:0] x);
    logic [31:0] w1;
    w1 = rom_f(x, 4'h1);
    chk(o_rom_addr, x);
    chk(o_free_run_tuning_word, rom_f(x, 4'h0));
    chk({o_vco_output_divider, o_output_pll_feedback_divider}, w1[23:0]);
    chk(o_channel_dividers, {rom_f(x, 4'h3), rom_f(x, 4'h2)});
    chk(o_reference_period, rom_f(x, 4'h4));
    chk(o_reference_divider, 20'(rom_f(x, 4'h5)));
    chk({o_dpll_integer_feedback, o_dpll_fractional_feedback}, {17'(rom_f(x, 4'h6)), 23'(rom_f(x, 4'h7))});
    chk(o_dpll_feedback_modulus, 23'(rom_f(x, 4'h8)));
  endtask
  task automatic summarize();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #500000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    logic [7:0] x;
    void'($urandom(32'h43fe));
    do_reset(1'b0);
    chk({o_busy, o_soft_reset, o_soft_sec1_active}, 3'b000);
    chk({o_soft_sec2_active, o_loop_bw_code, o_tolerance_code}, 5'h00);
    chk({o_ref_a_div, o_ref_b_div, o_chan0_div, o_chan1_div}, {4{5'h01}});
    for (int a = 0; a < 11; a++) rd(12'hc00 + 12'(a), 8'h00);
    // Section two: every scaling and loop code, A and B crossed
    wr(`SPL_ADDR_SEC2_EN, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(`SPL_ADDR_IN_SCALE, {4'h0, 2'(c), 2'(3 - c)});
      wr(`SPL_ADDR_OUT_SCALE, {4'h0, 2'(3 - c), 2'(c)});
      wr(`SPL_ADDR_LOOP_SET, {4'h0, 2'(c), 2'(3 - c)});
      idle(3);
      chk(o_soft_sec2_active, 1'b1);
      chk({o_ref_b_div, o_ref_a_div}, {div_tab[c], div_tab[3 - c]});
      chk({o_chan1_div, o_chan0_div}, {div_tab[3 - c], div_tab[c]});
      chk({o_loop_bw_code, o_tolerance_code}, {2'(c), 2'(3 - c)});
    end
    // Downloads for every system PLL code, random translation each time
    for (int c = 0; c < 4; c++) begin
      x = 8'($urandom);
      wr(`SPL_ADDR_SEC1_EN, 8'h01);
      wr(`SPL_ADDR_XLAT_SEL, x);
      wr(`SPL_ADDR_SPLL_SEL, 8'(c));
      wr(`SPL_ADDR_START, 8'h01);
      wait_busy(1'b1);
      wait_busy(1'b0);
      idle(1);
      dl_check(x);
      chk(o_sys_pll_config, spll_tab[c]);
      rd(`SPL_ADDR_START, 8'h00);
      rd(`SPL_ADDR_XLAT_SEL, x);
      rd(`SPL_ADDR_STATUS, 8'h02);
    end
    // Soft pin reset: one pulse, a download, register map kept
    sr_count = 0;
    wr(`SPL_ADDR_SP_RESET, 8'h01);
    wait_busy(1'b1);
    wait_busy(1'b0);
    idle(2);
    chk(sr_count, 1);
    dl_check(x);
    rd(`SPL_ADDR_SP_RESET, 8'h00);
    rd(`SPL_ADDR_XLAT_SEL, x);
    // Strap high at a second reset: soft settings take no effect
    do_reset(1'b1);
    wr(`SPL_ADDR_SEC1_EN, 8'h01);
    wr(`SPL_ADDR_SEC2_EN, 8'h01);
    wr(`SPL_ADDR_IN_SCALE, 8'h0f);
    wr(`SPL_ADDR_START, 8'h01);
    idle(40);
    chk({o_busy, o_soft_sec1_active}, 2'b00);
    chk({o_soft_sec2_active, o_ref_a_div}, 6'h01);
    rd(`SPL_ADDR_START, 8'h01);
    rd(`SPL_ADDR_STATUS, 8'h04);
    rd(`SPL_ADDR_SEC1_EN, 8'h01);
    idle(4);
    summarize();
  end
endmodule // test_soft_pin_profile_loader
